// ### core/bz_pkg.sv
package bz_pkg;

  // register offsets (byte-wide registers, printed addresses)
  localparam logic [15:0] ADDR_NOTE_A_DIV_LO  = 16'hA040;
  localparam logic [15:0] ADDR_NOTE_A_DIV_HI  = 16'hA041;
  localparam logic [15:0] ADDR_NOTE_A_LENGTH  = 16'hA042;
  localparam logic [15:0] ADDR_NOTE_A_GAP     = 16'hA043;
  localparam logic [15:0] ADDR_NOTE_B_DIV_LO  = 16'hA044;
  localparam logic [15:0] ADDR_NOTE_B_DIV_HI  = 16'hA045;
  localparam logic [15:0] ADDR_NOTE_B_LENGTH  = 16'hA046;
  localparam logic [15:0] ADDR_NOTE_B_GAP     = 16'hA047;
  localparam logic [15:0] ADDR_TONE_CONTROL   = 16'hA048;
  localparam logic [15:0] ADDR_POWER_WINDOW   = 16'hA049;
  localparam logic [15:0] ADDR_TIME_UNIT_CFG  = 16'hA04A;
  localparam logic [15:0] ADDR_IRQ_STATUS     = 16'hA04B;
  localparam logic [15:0] ADDR_IRQ_MASK       = 16'hA04C;

  // tone_control fields
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_INVERT_BIT = 6;
  localparam int CTRL_IEN_B_BIT  = 5;
  localparam int CTRL_IEN_A_BIT  = 4;
  localparam int CTRL_FLAG_B_BIT = 3;
  localparam int CTRL_FLAG_A_BIT = 2;
  localparam int CTRL_GO_B_BIT   = 1;
  localparam int CTRL_GO_A_BIT   = 0;

  // time_unit_config fields
  localparam int TU_SEL_MSB       = 7;
  localparam int TU_SEL_LSB       = 6;
  localparam int TU_PRESCALE_BIT  = 4;
  localparam int TU_POW_IEN_BIT   = 1;
  localparam int TU_POW_FLAG_BIT  = 0;

  // own interrupt status / mask bits
  localparam int IRQ_NOTE_A_BIT = 0;
  localparam int IRQ_NOTE_B_BIT = 1;
  localparam int IRQ_POW_BIT    = 2;

  localparam logic [7:0] REG_RESET = 8'h00;

  // timing
  localparam int CLK_FREQ_KHZ   = 125000;
  localparam int TIME_UNIT_MS   = 1;
  localparam int TICKS_PER_UNIT = CLK_FREQ_KHZ * TIME_UNIT_MS;
  localparam int TONE_DIV_LO    = 32;
  localparam int TONE_DIV_HI    = 64;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TONE = 3'b010,
    ST_GAP  = 3'b100
  } bz_state_e;

endpackage

// ### core/bz_melody_gen.sv
// How it works
// - tone frequency is prescaled clock divided by divisor plus one
// - prescale select 0 divides clock by 32, 1 divides by 64
// - length, gap and power window count in 1, 2, 4 or 8 ms units
// - a go bit write with the enable bit set restarts the power window timer with its value
// - power window expiry sets a sticky flag until software clears it
// - power window interrupt requested only while its enable bit is set
// - generator runs only while enable bit is one
// - polarity bit one inverts the tone output
// - note B end sets its flag when enabled; writing zero clears
// - note A end sets its flag when enabled; writing zero clears
// - writing one to note A go plays A; bit self-clears on completion
// - writing one to note B go plays B; bit self-clears on completion
// - both go bits set together play A first, then B
// - bit 0 of control reads note A playing status
// - bit 1 of control reads note B playing status
// - notes play once in sequence, or ping-pong when restarted by software
// - power window output drives external buzzer power switch
`timescale 1ns/1ps

module bz_melody_gen
  import bz_pkg::*;
#(
  parameter int P_TICKS_PER_UNIT = TICKS_PER_UNIT
)(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  output logic             o_tone_output,
  output logic             o_power_window,
  output logic             o_irq
);

  localparam int MS_W = $clog2(P_TICKS_PER_UNIT + 1);

  typedef struct packed {
    logic [11:0] div_a;
    logic [7:0]  len_a;
    logic [7:0]  gap_a;
    logic [11:0] div_b;
    logic [7:0]  len_b;
    logic [7:0]  gap_b;
    logic        enable;
    logic        invert;
    logic        ien_b;
    logic        ien_a;
    logic        flag_b;
    logic        flag_a;
    logic        go_b;
    logic        go_a;
    logic [7:0]  pow_val;
    logic [1:0]  unit_sel;
    logic        pre_sel;
    logic        pow_ien;
    logic        pow_flag;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    bz_state_e   st;
    logic        cur_b;
    logic [MS_W-1:0] ms_cnt;
    logic [2:0]  unit_cnt;
    logic [4:0]  pre_cnt;
    logic [11:0] tone_cnt;
    logic        tone_lvl;
    logic [7:0]  ivl_cnt;
    logic        pow_run;
    logic [7:0]  pow_cnt;
    logic [7:0]  rdata;
    logic        pin;
    logic        irq;
  } bz_core_s;

  bz_core_s s;
  bz_core_s next_s;

  function automatic logic [2:0] unit_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    unit_mask = 3'h0;
      2'h1:    unit_mask = 3'h1;
      2'h2:    unit_mask = 3'h3;
      default: unit_mask = 3'h7;
    endcase
  endfunction

  function automatic logic [7:0] rd_mux(input logic [15:0] addr, input bz_core_s r);
    logic play_a;
    logic play_b;
    play_a = (r.st != ST_IDLE) && !r.cur_b;
    play_b = (r.st != ST_IDLE) && r.cur_b;
    case (addr)
      ADDR_NOTE_A_DIV_LO: rd_mux = r.div_a[7:0];
      ADDR_NOTE_A_DIV_HI: rd_mux = {4'h0, r.div_a[11:8]};
      ADDR_NOTE_A_LENGTH: rd_mux = r.len_a;
      ADDR_NOTE_A_GAP:    rd_mux = r.gap_a;
      ADDR_NOTE_B_DIV_LO: rd_mux = r.div_b[7:0];
      ADDR_NOTE_B_DIV_HI: rd_mux = {4'h0, r.div_b[11:8]};
      ADDR_NOTE_B_LENGTH: rd_mux = r.len_b;
      ADDR_NOTE_B_GAP:    rd_mux = r.gap_b;
      ADDR_TONE_CONTROL:  rd_mux = {r.enable, r.invert, r.ien_b, r.ien_a,
                                    r.flag_b, r.flag_a, play_b, play_a};
      ADDR_POWER_WINDOW:  rd_mux = r.pow_val;
      ADDR_TIME_UNIT_CFG: rd_mux = {r.unit_sel, 1'b0, r.pre_sel, 2'b00, r.pow_ien, r.pow_flag};
      ADDR_IRQ_STATUS:    rd_mux = {5'h00, r.irq_stat};
      ADDR_IRQ_MASK:      rd_mux = {5'h00, r.irq_mask};
      default:            rd_mux = REG_RESET;
    endcase
  endfunction

  logic ms_tick;
  logic unit_tick;
  logic half_tick;
  logic wr_ctrl;
  logic go_ok;
  logic go_a_req;
  logic go_b_req;
  logic go_req;
  logic note_done;
  logic [11:0] cur_div;

  assign ms_tick = (s.ms_cnt == MS_W'(P_TICKS_PER_UNIT - 1));
  // unit tick every 1/2/4/8 base units
  assign unit_tick = ms_tick && ((s.unit_cnt & unit_mask(s.unit_sel)) == unit_mask(s.unit_sel));
  // half-period base: 16 or 32 clocks, so a full tone period is 32 or 64 per step
  assign half_tick = s.pre_sel ? (s.pre_cnt == 5'(TONE_DIV_HI / 2 - 1))
                               : (s.pre_cnt[3:0] == 4'(TONE_DIV_LO / 2 - 1));
  assign wr_ctrl   = i_wr && (i_addr == ADDR_TONE_CONTROL);
  // go is honoured only by a write that leaves the generator enabled
  assign go_ok     = wr_ctrl && i_wdata[CTRL_ENABLE_BIT];
  assign go_a_req  = go_ok && i_wdata[CTRL_GO_A_BIT];
  assign go_b_req  = go_ok && i_wdata[CTRL_GO_B_BIT];
  assign go_req    = go_a_req || go_b_req;
  assign note_done = (s.st == ST_GAP) && (s.ivl_cnt == 8'h00) && s.enable;
  assign cur_div   = s.cur_b ? s.div_b : s.div_a;

  always_comb
  begin
    next_s       = s;
    next_s.rdata = REG_RESET;
    next_s.ms_cnt  = ms_tick ? '0 : MS_W'(s.ms_cnt + 1'b1);
    next_s.pre_cnt = 5'(s.pre_cnt + 5'h01);
    next_s.unit_cnt = ms_tick ? 3'(s.unit_cnt + 3'h1) : s.unit_cnt;

    if (i_wr)
    begin
      case (i_addr)
        ADDR_NOTE_A_DIV_LO: next_s.div_a[7:0]  = i_wdata;
        ADDR_NOTE_A_DIV_HI: next_s.div_a[11:8] = i_wdata[3:0];
        ADDR_NOTE_A_LENGTH: next_s.len_a       = i_wdata;
        ADDR_NOTE_A_GAP:    next_s.gap_a       = i_wdata;
        ADDR_NOTE_B_DIV_LO: next_s.div_b[7:0]  = i_wdata;
        ADDR_NOTE_B_DIV_HI: next_s.div_b[11:8] = i_wdata[3:0];
        ADDR_NOTE_B_LENGTH: next_s.len_b       = i_wdata;
        ADDR_NOTE_B_GAP:    next_s.gap_b       = i_wdata;
        ADDR_TONE_CONTROL:
        begin
          next_s.enable = i_wdata[CTRL_ENABLE_BIT];
          next_s.invert = i_wdata[CTRL_INVERT_BIT];
          next_s.ien_b  = i_wdata[CTRL_IEN_B_BIT];
          next_s.ien_a  = i_wdata[CTRL_IEN_A_BIT];
          // flags clear on a written zero, a one leaves them
          next_s.flag_b = s.flag_b & i_wdata[CTRL_FLAG_B_BIT];
          next_s.flag_a = s.flag_a & i_wdata[CTRL_FLAG_A_BIT];
          // a written zero to go has no effect
          next_s.go_a   = s.go_a | go_a_req;
          next_s.go_b   = s.go_b | go_b_req;
        end
        ADDR_POWER_WINDOW:  next_s.pow_val = i_wdata;
        ADDR_TIME_UNIT_CFG:
        begin
          next_s.unit_sel = i_wdata[TU_SEL_MSB:TU_SEL_LSB];
          next_s.pre_sel  = i_wdata[TU_PRESCALE_BIT];
          next_s.pow_ien  = i_wdata[TU_POW_IEN_BIT];
          next_s.pow_flag = s.pow_flag & i_wdata[TU_POW_FLAG_BIT];
        end
        ADDR_IRQ_STATUS:    next_s.irq_stat = s.irq_stat & ~i_wdata[2:0];
        ADDR_IRQ_MASK:      next_s.irq_mask = i_wdata[2:0];
        default:            next_s.rdata = REG_RESET;
      endcase
    end

    if (i_rd)
    begin
      next_s.rdata = rd_mux(i_addr, s);
    end

    // any start restarts the power window
    if (go_req)
    begin
      next_s.pow_run = 1'b1;
      next_s.pow_cnt = s.pow_val;
    end
    else if (s.pow_run)
    begin
      if (s.pow_cnt == 8'h00)
      begin
        // sticky expiry flag, set beats a same-cycle clear
        next_s.pow_run  = 1'b0;
        next_s.pow_flag = 1'b1;
        next_s.irq_stat[IRQ_POW_BIT] = next_s.irq_stat[IRQ_POW_BIT] | s.pow_ien;
      end
      else if (unit_tick)
      begin
        next_s.pow_cnt = 8'(s.pow_cnt - 8'h01);
      end
    end

    case (s.st)
      ST_IDLE:
      begin
        // A wins when both are pending; software re-arms for ping-pong
        if (next_s.enable && (next_s.go_a || next_s.go_b))
        begin
          next_s.st       = ST_TONE;
          next_s.cur_b    = !next_s.go_a;
          next_s.ivl_cnt  = next_s.go_a ? next_s.len_a : next_s.len_b;
          next_s.tone_cnt = 12'h000;
          next_s.tone_lvl = 1'b1;
          // unit timers restart so the first unit is a whole one
          next_s.ms_cnt   = '0;
          next_s.unit_cnt = 3'h0;
          next_s.pre_cnt  = 5'h00;
        end
      end
      ST_TONE:
      begin
        // sound phase, then the silent gap
        if (s.ivl_cnt == 8'h00)
        begin
          next_s.st       = ST_GAP;
          next_s.ivl_cnt  = s.cur_b ? s.gap_b : s.gap_a;
          next_s.tone_lvl = 1'b0;
        end
        else
        begin
          if (unit_tick)
          begin
            next_s.ivl_cnt = 8'(s.ivl_cnt - 8'h01);
          end
          if (half_tick)
          begin
            if (s.tone_cnt == cur_div)
            begin
              next_s.tone_cnt = 12'h000;
              next_s.tone_lvl = !s.tone_lvl;
            end
            else
            begin
              next_s.tone_cnt = 12'(s.tone_cnt + 12'h001);
            end
          end
        end
      end
      ST_GAP:
      begin
        if (note_done)
        begin
          next_s.st = ST_IDLE;
          if (s.cur_b)
          begin
            // self-clear, unless re-armed in this very cycle
            next_s.go_b = go_b_req;
            if (s.ien_b)
            begin
              next_s.flag_b                   = 1'b1;
              next_s.irq_stat[IRQ_NOTE_B_BIT] = 1'b1;
            end
          end
          else
          begin
            // self-clear, unless re-armed in this very cycle
            next_s.go_a = go_a_req;
            if (s.ien_a)
            begin
              next_s.flag_a                   = 1'b1;
              next_s.irq_stat[IRQ_NOTE_A_BIT] = 1'b1;
            end
          end
        end
        else if (unit_tick)
        begin
          next_s.ivl_cnt = 8'(s.ivl_cnt - 8'h01);
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // disable aborts everything, no end flags raised
    if (!next_s.enable)
    begin
      next_s.st       = ST_IDLE;
      next_s.go_a     = 1'b0;
      next_s.go_b     = 1'b0;
      next_s.pow_run  = 1'b0;
      next_s.tone_lvl = 1'b0;
    end

    // inactive level is the polarity bit itself
    next_s.pin = ((next_s.st == ST_TONE) && next_s.tone_lvl) ^ next_s.invert;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      s    <= '0;
      s.st <= ST_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_rdata        = s.rdata;
  assign o_tone_output  = s.pin;
  // power switch follows the window timer
  assign o_power_window = s.pow_run;
  assign o_irq          = s.irq;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  AST_IDLE_LEVEL: assert property (s.st != ST_TONE |-> o_tone_output == s.invert)
    else $error("output not at inactive level outside tone phase");
  AST_DISABLE_HALTS: assert property ((!s.enable && !go_ok) |=> s.st == ST_IDLE && !o_power_window)
    else $error("generator active while disabled");
  AST_GO_A_LATCH: assert property ((go_a_req && s.enable) |=> s.go_a || s.st != ST_IDLE)
    else $error("note A start not taken");
  AST_POW_START: assert property (go_req |=> o_power_window && s.pow_cnt == $past(s.pow_val))
    else $error("power window not restarted by start");
  AST_POW_EXPIRE: assert property ((s.pow_run && s.pow_cnt == 8'h00 && !go_req && next_s.enable)
                                   |=> s.pow_flag && !o_power_window)
    else $error("power window expiry did not set flag");
  AST_POW_IRQ_GATE: assert property ((s.pow_run && s.pow_cnt == 8'h00 && !s.pow_ien && !go_req
                                      && !s.irq_stat[IRQ_POW_BIT]) |=> !s.irq_stat[IRQ_POW_BIT])
    else $error("power window interrupt raised while disabled");
  AST_A_END_FLAG: assert property ((note_done && !s.cur_b && s.ien_a) |=> s.flag_a ##1 s.flag_a || $past(wr_ctrl))
    else $error("note A end flag not set");
  AST_B_END_FLAG: assert property ((note_done && s.cur_b && s.ien_b) |=> s.flag_b && !s.go_b || $past(go_b_req))
    else $error("note B end flag or go clear wrong");
  AST_A_FIRST: assert property ((s.st == ST_IDLE && go_a_req && go_b_req)
                                |=> s.st == ST_TONE && !s.cur_b && s.go_b)
    else $error("note B played before note A");
  AST_BUSY_READ: assert property (i_rd && i_addr == ADDR_TONE_CONTROL
                                  |=> o_rdata[CTRL_GO_A_BIT] == ($past(s.st) != ST_IDLE && !$past(s.cur_b)))
    else $error("note A busy readback wrong");
  AST_TONE_TOGGLE: assert property ((s.st == ST_TONE && s.ivl_cnt != 8'h00 && half_tick && s.tone_cnt == cur_div
                                     && next_s.enable) |=> s.tone_lvl != $past(s.tone_lvl))
    else $error("tone did not toggle after divisor steps");

  COV_NOTE_A_DONE: cover property (note_done && !s.cur_b);
  COV_A_THEN_B: cover property (note_done && !s.cur_b ##[1:4] s.st == ST_TONE && s.cur_b);
  COV_POW_EXPIRE: cover property (s.pow_run && s.pow_cnt == 8'h00 && s.pow_ien);

endmodule // bz_melody_gen

// ### verification/bz_buzzer_model.sv
`timescale 1ns/1ps

module bz_buzzer_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_clear,
  input  wire logic        i_tone_output,
  input  wire logic        i_power_window,
  output logic      [15:0] o_half_period,
  output logic      [7:0]  o_edges
);
  logic        prev;
  logic [15:0] run;

  // element only sounds while its power switch is closed
  always_ff @(posedge i_clk_sys)
  begin
    prev <= i_tone_output;
    run  <= (prev != i_tone_output) ? 16'h0001 : run + 16'h0001;
    if (i_clear)
    begin
      o_edges       <= 8'h00;
      o_half_period <= 16'h0000;
    end
    else if (prev != i_tone_output && i_power_window)
    begin
      o_edges <= o_edges + 8'h01;
      // second half period, between the second and third edges, clear of the note start
      if (o_edges == 8'h02)
        o_half_period <= run;
    end
  end
endmodule // bz_buzzer_model

// ### verification/buzzer_melody_tone_generator_tb_top.sv
`timescale 1ns/1ps

module buzzer_melody_tone_generator_tb_top;
  import bz_pkg::*;
  localparam int UNIT = 64;
  logic        i_clk_sys = 1'b0;
  logic        i_reset   = 1'b1;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        clr       = 1'b1;
  logic [15:0] i_addr    = 16'h0000;
  logic [7:0]  i_wdata   = 8'h00;
  logic [7:0]  o_rdata;
  logic        o_tone_output;
  logic        o_power_window;
  logic        o_irq;
  logic [15:0] half;
  logic [7:0]  d;
  logic [15:0] n;
  int          fails  = 0;
  int          checks = 0;

  bz_melody_gen #(.P_TICKS_PER_UNIT(UNIT)) i_dut (
    .i_clk_sys     (i_clk_sys),
    .i_reset       (i_reset),
    .i_addr        (i_addr),
    .i_wdata       (i_wdata),
    .i_wr          (i_wr),
    .i_rd          (i_rd),
    .o_rdata       (o_rdata),
    .o_tone_output (o_tone_output),
    .o_power_window(o_power_window),
    .o_irq         (o_irq)
  );

  bz_buzzer_model i_buzzer (
    .i_clk_sys     (i_clk_sys),
    .i_clear       (clr),
    .i_tone_output (o_tone_output),
    .i_power_window(o_power_window),
    .o_half_period (half),
    .o_edges       ()
  );

  initial
  begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input logic [15:0] lo, input logic [15:0] hi,
                             input logic [15:0] got);
    checks++;
    if (!(got >= lo && got <= hi))
    begin
      fails++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  // poll the playing bits under a bound
  task automatic wait_idle(input logic [7:0] m);
    int k;
    k = 0;
    rd(ADDR_TONE_CONTROL, d);
    while ((d & m) != 8'h00 && k < 1000)
    begin
      rd(ADDR_TONE_CONTROL, d);
      k++;
    end
    if (k == 1000)
    begin
      fails++;
      tally_and_finish();
    end
  endtask

  // exp: control readback once the first note plays
  task automatic play(input logic [7:0] ctrl, input logic [7:0] exp);
    clr <= 1'b1;
    @(posedge i_clk_sys);
    clr <= 1'b0;
    wr(ADDR_TONE_CONTROL, ctrl);
    rd(ADDR_TONE_CONTROL, d);
    check("playing status", {8'h00, exp}, {8'h00, d});
  endtask

  initial
  begin
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    clr     <= 1'b0;
    check("outputs at reset", 16'h0000, {13'h0000, o_tone_output, o_power_window, o_irq});
    for (int a = 16'hA040; a <= 16'hA04D; a++)
    begin
      rd(a[15:0], d);
      check("register reset", 16'h0000, {8'h00, d});
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(16'hA040 + i[15:0], 8'h01 + i[7:0]);
      rd(16'hA040 + i[15:0], d);
      check("register readback", {8'h00, 8'h01 + i[7:0]}, {8'h00, d});
    end
    wr(16'hA04D, 8'hFF);
    rd(16'hA04D, d);
    check("unmapped read", 16'h0000, {8'h00, d});
    // note A: divisor 1, length 4, gap 1; note B: divisor 2, length 4, gap 1
    wr(ADDR_NOTE_A_DIV_LO, 8'h01);
    wr(ADDR_NOTE_A_DIV_HI, 8'h00);
    wr(ADDR_NOTE_A_LENGTH, 8'h04);
    wr(ADDR_NOTE_A_GAP, 8'h01);
    wr(ADDR_NOTE_B_DIV_LO, 8'h02);
    wr(ADDR_NOTE_B_DIV_HI, 8'h00);
    wr(ADDR_NOTE_B_LENGTH, 8'h04);
    wr(ADDR_NOTE_B_GAP, 8'h01);
    wr(ADDR_POWER_WINDOW, 8'h0A);
    wr(ADDR_TIME_UNIT_CFG, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h07);
    wr(ADDR_TONE_CONTROL, 8'h01);
    rd(ADDR_TONE_CONTROL, d);
    check("go while disabled", 16'h0000, {8'h00, d});
    play(8'h91, 8'h91);
    check("power window on start", 16'h0001, {15'h0000, o_power_window});
    wait_idle(8'h03);
    check("half period div1 base32", 16'd32, half);
    rd(ADDR_TONE_CONTROL, d);
    check("note A end flag", 16'h0094, {8'h00, d});
    check("irq level", 16'h0001, {15'h0000, o_irq});
    n = 16'h0000;
    while (o_power_window !== 1'b0 && n < 16'd2000)
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    check("power window expired", 16'h0000, {15'h0000, o_power_window});
    rd(ADDR_IRQ_STATUS, d);
    check("pow status while disabled", 16'h0001, {8'h00, d});
    wr(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_TONE_CONTROL, 8'h90);
    rd(ADDR_TONE_CONTROL, d);
    check("flag A cleared by zero", 16'h0090, {8'h00, d});
    check("irq released", 16'h0000, {15'h0000, o_irq});
    wr(ADDR_TIME_UNIT_CFG, 8'h10);
    play(8'hA2, 8'hA2);
    wait_idle(8'h03);
    check("half period div2 base64", 16'd96, half);
    rd(ADDR_TONE_CONTROL, d);
    check("note B end flag", 16'h00A8, {8'h00, d});
    wr(ADDR_TIME_UNIT_CFG, 8'h00);
    // written zeros clear both flags; only note A plays at first
    play(8'hB3, 8'hB1);
    wait_idle(8'h01);
    rd(ADDR_TONE_CONTROL, d);
    check("B follows A", 16'h0002, {14'h0000, d[1:0]});
    wait_idle(8'h03);
    rd(ADDR_TONE_CONTROL, d);
    check("both end flags", 16'h00BC, {8'h00, d});
    wr(ADDR_TONE_CONTROL, 8'hC0);
    @(posedge i_clk_sys);
    #1 check("inverted idle level", 16'h0001, {15'h0000, o_tone_output});
    wr(ADDR_TONE_CONTROL, 8'h00);
    wr(ADDR_NOTE_A_LENGTH, 8'h00);
    wr(ADDR_NOTE_A_GAP, 8'h00);
    wr(ADDR_POWER_WINDOW, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_IRQ_STATUS, 8'h07);
      wr(ADDR_TIME_UNIT_CFG, {s[1:0], 6'h02});
      wr(ADDR_TONE_CONTROL, 8'h81);
      n = 16'h0000;
      #1;
      while (o_power_window === 1'b1 && n < 16'd5000)
      begin
        @(posedge i_clk_sys);
        #1 n++;
      end
      check_range("power window length", UNIT << s, (UNIT << s) + 2, n);
      rd(ADDR_TIME_UNIT_CFG, d);
      check("pow flag set", {8'h00, s[1:0], 6'h03}, {8'h00, d});
      rd(ADDR_IRQ_STATUS, d);
      check("pow status", 16'h0004, {8'h00, d});
      check("pow irq", 16'h0001, {15'h0000, o_irq});
      wr(ADDR_TIME_UNIT_CFG, {s[1:0], 6'h02});
      rd(ADDR_TIME_UNIT_CFG, d);
      check("pow flag cleared", {8'h00, s[1:0], 6'h02}, {8'h00, d});
    end
    tally_and_finish();
  end
endmodule // buzzer_melody_tone_generator_tb_top
